// File: design/sdci_core.sv
// Command sequencing, burst interruption and byte masking of a two-bank
// synchronous DRAM, seen from inside the device.
// Assumes the controller drives all pins on the rising edge of i_clk.
//
// Functional notes
// (R1) Auto precharge starts two clocks after last word
// (R2) Full page ignores write auto precharge
// (R3) Controller targets only active banks
// (R4) New read replaces old data after latency
// (R5) Controller spaces column commands one clock apart
// (R6) New write takes data from its own clock
// (R7) Read after write outputs after latency
// (R8) Write interrupting read accepts data immediately
// (R9) Precharge one bank, or both when flagged
// (R10) Bank idles row precharge time after precharge
// (R11) Precharge ends read output after latency clocks
// (R12) Precharge stops write storing that same clock
// (R13) Controller masks bytes with write-interrupting precharge
// (R14) Other-bank precharge leaves write burst running
// (R15) Controller waits two clocks before precharge
// (R16) Full page wraps after 256 columns
// (R17) Controller ends full page with burst stop
// (R18) Burst stop ends read output after latency
// (R19) Burst stop ends write immediately
// (R20) Read mask floats lane two clocks later
// (R21) Each mask pin governs its own lane
// (R22) Masked reads keep the burst counter moving
// (R23) Write mask blocks lanes with no latency
// (R24) Each bank tracks its own idle state
`timescale 1ns/1ps
`default_nettype none

module sdci_core #(
   parameter int ROW_W = 11
) (
   input  wire logic                           i_clk,
   input  wire logic                           i_sys_rst,
   input  wire logic                           i_cs_n,
   input  wire logic                           i_ras_n,
   input  wire logic                           i_cas_n,
   input  wire logic                           i_we_n,
   input  wire logic [sdci_pkg::ADDR_W-1:0]    i_addr,
   input  wire logic                           i_upper_byte_mask,
   input  wire logic                           i_lower_byte_mask,
   input  wire logic [sdci_pkg::DQ_W-1:0]      i_dq,
   input  wire logic                           i_cas_latency3,
   input  wire logic [sdci_pkg::BL_W-1:0]      i_burst_len,
   input  wire logic                           i_interleave,
   output logic      [sdci_pkg::DQ_W-1:0]      o_dq,
   output logic      [sdci_pkg::LANES-1:0]     o_dq_oe,
   output logic      [sdci_pkg::BANKS-1:0]     o_bank_active,
   output logic                                o_read_busy,
   output logic                                o_write_busy
);
   import sdci_pkg::*;

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   localparam int MA_W  = 1 + ROW_W + COL_W;
   localparam int DEPTH = 2 ** MA_W;

   logic [DQ_W-1:0] mem [0:DEPTH-1];

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [COL_W-1:0] len_m1_of(input logic [BL_W-1:0] code);
      logic [COL_W-1:0] r;
      r = 8'h00;
      case (code)
         BL_2:    r = 8'h01;
         BL_4:    r = 8'h03;
         BL_8:    r = 8'h07;
         BL_FULL: r = 8'hFF;
         default: r = 8'h00;
      endcase
      return r;
   endfunction : len_m1_of

   // Column for word cnt of a burst; short bursts wrap inside their block.
   function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] base,
                                               input logic [COL_W-1:0] cnt,
                                               input logic [COL_W-1:0] lm1,
                                               input logic             full,
                                               input logic             il);
      logic [COL_W-1:0] step;
      step = il ? (base ^ cnt) : COL_W'(base + cnt);
      return full ? COL_W'(base + cnt) : ((base & ~lm1) | (step & lm1));
   endfunction : col_of

   // ------------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------------
   logic             [2:0]        cmd;
   logic                          is_act;
   logic                          is_rd;
   logic                          is_wr;
   logic                          is_pre;
   logic                          is_bst;
   logic                          cmd_bank;
   logic             [BANKS-1:0]  pre_sel;
   logic                          bank_ok;
   logic                          rd_go;
   logic                          wr_go;
   logic             [COL_W-1:0]  cfg_lm1;
   logic                          cfg_full;
   logic             [COL_W-1:0]  cmd_col;
   sdci_bank_e                    bank_reg [BANKS];
   logic             [ROW_W-1:0]  row_reg [BANKS];
   logic             [RP_W-1:0]   rp_cnt_reg [BANKS];
   logic             [1:0]        ap_cnt_reg [BANKS];
   assign cmd      = {i_ras_n, i_cas_n, i_we_n};
   assign is_act   = !i_cs_n && (cmd == CMD_ACT);
   assign is_rd    = !i_cs_n && (cmd == CMD_RD);
   assign is_wr    = !i_cs_n && (cmd == CMD_WR);
   assign is_pre   = !i_cs_n && (cmd == CMD_PRE);
   assign is_bst   = !i_cs_n && (cmd == CMD_BST);
   assign cmd_bank = i_addr[BANK_SELECT_BIT];
   assign cmd_col  = i_addr[COL_W-1:0];
   assign cfg_lm1  = len_m1_of(i_burst_len);
   assign cfg_full = (i_burst_len == BL_FULL);
   // (R9) bank selection
   assign pre_sel  = i_addr[ALL_BANK_PRECHARGE_BIT] ? 2'h3 : (cmd_bank ? 2'h2 : 2'h1);
   // (R3) active bank only
   assign bank_ok  = (bank_reg[cmd_bank] == BANK_ACTIVE);
   assign rd_go    = is_rd && bank_ok;
   assign wr_go    = is_wr && bank_ok;

   // ------------------------------------------------------------------
   // Write burst
   // ------------------------------------------------------------------
   logic                          wr_active_reg;
   logic                          wr_bank_reg;
   logic             [COL_W-1:0]  wr_base_reg;
   logic             [COL_W-1:0]  wr_cnt_reg;
   logic             [COL_W-1:0]  wr_lm1_reg;
   logic                          wr_full_reg;
   logic                          wr_ap_reg;
   logic                          wr_il_reg;
   logic                          wr_stop;
   logic                          wr_cont;
   logic                          wr_last;
   logic                          wr_en;
   logic             [MA_W-1:0]   wr_addr;
   logic             [LANES-1:0]  wr_be;
   logic                          ap_req;
   logic                          ap_bank;

   // (R12) same-bank precharge stops
   // (R14) other bank leaves burst
   // (R19) burst stop ends write
   assign wr_stop = is_bst || rd_go || wr_go || (is_pre && pre_sel[wr_bank_reg]);
   assign wr_cont = wr_active_reg && !wr_stop;
   assign wr_last = wr_cont && !wr_full_reg && (wr_cnt_reg == wr_lm1_reg);
   assign wr_en   = wr_go || wr_cont;
   // (R6) new write from its clock
   // (R8) write data taken at once
   assign wr_addr = wr_go ? {cmd_bank, row_reg[cmd_bank], cmd_col}
                          : {wr_bank_reg, row_reg[wr_bank_reg],
                             col_of(wr_base_reg, wr_cnt_reg, wr_lm1_reg, wr_full_reg, wr_il_reg)};
   // (R21) lane per mask
   // (R23) zero latency mask
   assign wr_be   = ~{i_upper_byte_mask, i_lower_byte_mask};
   // (R2) no auto precharge in full page
   assign ap_req  = (wr_go && i_addr[AUTO_PRECHARGE_BIT] && !cfg_full && (cfg_lm1 == 8'h00))
                 || (wr_last && wr_ap_reg);
   assign ap_bank = wr_go ? cmd_bank : wr_bank_reg;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_active_reg <= 1'b0;
         wr_bank_reg   <= 1'b0;
         wr_base_reg   <= 8'h00;
         wr_cnt_reg    <= 8'h00;
         wr_lm1_reg    <= 8'h00;
         wr_full_reg   <= 1'b0;
         wr_ap_reg     <= 1'b0;
         wr_il_reg     <= 1'b0;
      end else if (wr_go) begin
         wr_active_reg <= cfg_full || (cfg_lm1 != 8'h00);
         wr_bank_reg   <= cmd_bank;
         wr_base_reg   <= cmd_col;
         wr_cnt_reg    <= 8'h01;
         wr_lm1_reg    <= cfg_lm1;
         wr_full_reg   <= cfg_full;
         wr_ap_reg     <= i_addr[AUTO_PRECHARGE_BIT] && !cfg_full;
         wr_il_reg     <= i_interleave;
      end else if (wr_cont) begin
         // (R16) full page wraps
         wr_cnt_reg    <= COL_W'(wr_cnt_reg + 8'h01);
         if (wr_last) begin
            wr_active_reg <= 1'b0;
         end
      end else begin
         wr_active_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (wr_en) begin
         for (int l = 0; l < LANES; l++) begin
            if (wr_be[l]) begin
               mem[wr_addr][l*8 +: 8] <= i_dq[l*8 +: 8];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Read burst
   // ------------------------------------------------------------------
   logic                          rd_active_reg;
   logic                          rd_bank_reg;
   logic             [COL_W-1:0]  rd_base_reg;
   logic             [COL_W-1:0]  rd_cnt_reg;
   logic             [COL_W-1:0]  rd_lm1_reg;
   logic                          rd_full_reg;
   logic                          rd_il_reg;
   logic                          rd_cont;
   logic                          rd_last;
   logic                          rd_issue;
   logic             [MA_W-1:0]   rd_addr;

   // (R11) precharge stops fetching
   // (R18) burst stop stops fetching
   assign rd_cont  = rd_active_reg && !(is_bst || rd_go || wr_go
                                        || (is_pre && pre_sel[rd_bank_reg]));
   assign rd_last  = rd_cont && !rd_full_reg && (rd_cnt_reg == rd_lm1_reg);
   assign rd_issue = rd_go || rd_cont;
   assign rd_addr  = rd_go ? {cmd_bank, row_reg[cmd_bank], cmd_col}
                           : {rd_bank_reg, row_reg[rd_bank_reg],
                              col_of(rd_base_reg, rd_cnt_reg, rd_lm1_reg, rd_full_reg, rd_il_reg)};
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         rd_active_reg <= 1'b0;
         rd_bank_reg   <= 1'b0;
         rd_base_reg   <= 8'h00;
         rd_cnt_reg    <= 8'h00;
         rd_lm1_reg    <= 8'h00;
         rd_full_reg   <= 1'b0;
         rd_il_reg     <= 1'b0;
      end else if (rd_go) begin
         // (R4) new read restarts burst
         rd_active_reg <= cfg_full || (cfg_lm1 != 8'h00);
         rd_bank_reg   <= cmd_bank;
         rd_base_reg   <= cmd_col;
         rd_cnt_reg    <= 8'h01;
         rd_lm1_reg    <= cfg_lm1;
         rd_full_reg   <= cfg_full;
         rd_il_reg     <= i_interleave;
      end else if (rd_cont) begin
         // (R22) counter runs when masked
         rd_cnt_reg    <= COL_W'(rd_cnt_reg + 8'h01);
         if (rd_last) begin
            rd_active_reg <= 1'b0;
         end
      end else begin
         rd_active_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Output pipeline
   // ------------------------------------------------------------------
   // Words already fetched keep draining, so an interrupted burst still
   // shows latency-minus-one trailing words (one at CL2, two at CL3) before the lanes float.
   logic             [1:0]        pv_reg;
   logic             [DQ_W-1:0]   pd_reg [2];
   logic             [LANES-1:0]  mask_reg;
   logic                          out_v;
   logic             [DQ_W-1:0]   out_d;
   always_ff @(posedge i_clk) begin
      pd_reg[0] <= mem[rd_addr];
      pd_reg[1] <= pd_reg[0];
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pv_reg   <= 2'h0;
         mask_reg <= 2'h0;
      end else begin
         pv_reg   <= {pv_reg[0], rd_issue};
         mask_reg <= {i_upper_byte_mask, i_lower_byte_mask};
      end
   end

   // (R7) data after latency
   // (R4) replacement data after latency
   assign out_v = i_cas_latency3 ? pv_reg[1] : pv_reg[0];
   assign out_d = i_cas_latency3 ? pd_reg[1] : pd_reg[0];
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_dq    <= DQ_RESET;
         o_dq_oe <= 2'h0;
      end else begin
         o_dq    <= out_d;
         // (R20) mask floats two later
         // (R21) independent lanes
         o_dq_oe <= {LANES{out_v}} & ~mask_reg;
      end
   end

   // ------------------------------------------------------------------
   // Bank state
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      for (int b = 0; b < BANKS; b++) begin
         if (i_sys_rst) begin
            bank_reg[b]   <= BANK_IDLE;
            row_reg[b]    <= '0;
            rp_cnt_reg[b] <= '0;
            ap_cnt_reg[b] <= 2'h0;
         end else begin
            // (R1) two clock auto precharge wait
            if (ap_req && (ap_bank == b[0])) begin
               ap_cnt_reg[b] <= WR_AP_CLK;
            end else if (ap_cnt_reg[b] != 2'h0) begin
               ap_cnt_reg[b] <= ap_cnt_reg[b] - 2'h1;
            end
            // (R24) per bank state
            unique case (bank_reg[b])
               BANK_IDLE: begin
                  if (is_act && (cmd_bank == b[0])) begin
                     bank_reg[b] <= BANK_ACTIVE;
                     row_reg[b]  <= i_addr[ROW_W-1:0];
                  end
               end
               BANK_ACTIVE: begin
                  // (R9) selected or both banks
                  // (R1) auto precharge begins
                  if ((is_pre && pre_sel[b]) || (ap_cnt_reg[b] == 2'h1)) begin
                     bank_reg[b]   <= BANK_PRECH;
                     rp_cnt_reg[b] <= RP_CYCLES;
                     ap_cnt_reg[b] <= 2'h0;
                  end
               end
               BANK_PRECH: begin
                  // (R10) idle after precharge time
                  if (rp_cnt_reg[b] <= RP_W'(1)) begin
                     bank_reg[b] <= BANK_IDLE;
                  end else begin
                     rp_cnt_reg[b] <= rp_cnt_reg[b] - RP_W'(1);
                  end
               end
               default: begin
                  bank_reg[b] <= BANK_IDLE;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Status
   // ------------------------------------------------------------------
   always_comb begin
      for (int b = 0; b < BANKS; b++) begin
         o_bank_active[b] = (bank_reg[b] == BANK_ACTIVE);
      end
   end

   assign o_read_busy  = rd_active_reg;
   assign o_write_busy = wr_active_reg;
endmodule : sdci_core

`default_nettype wire

// File: design/sdci_pkg.sv
// Constants for the two-bank synchronous DRAM command and burst core.
// Assumes a single 100 MHz clock shared with the memory controller.
package sdci_pkg;

   // ------------------------------------------------------------------
   // Widths and geometry
   // ------------------------------------------------------------------
   localparam int DQ_W      = 16;
   localparam int ADDR_W    = 12;
   localparam int COL_W     = 8;
   localparam int BANKS     = 2;
   localparam int LANES     = 2;
   localparam int BL_W      = 3;

   // ------------------------------------------------------------------
   // Address bit positions
   // ------------------------------------------------------------------
   localparam int ALL_BANK_PRECHARGE_BIT = 10;
   localparam int AUTO_PRECHARGE_BIT     = 10;
   localparam int BANK_SELECT_BIT        = 11;

   // ------------------------------------------------------------------
   // Commands, coded as {ras_n, cas_n, we_n} with chip select low
   // ------------------------------------------------------------------
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_RD  = 3'h5;
   localparam logic [2:0] CMD_WR  = 3'h4;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_BST = 3'h6;

   // ------------------------------------------------------------------
   // Burst length codes
   // ------------------------------------------------------------------
   localparam logic [BL_W-1:0] BL_1    = 3'h0;
   localparam logic [BL_W-1:0] BL_2    = 3'h1;
   localparam logic [BL_W-1:0] BL_4    = 3'h2;
   localparam logic [BL_W-1:0] BL_8    = 3'h3;
   localparam logic [BL_W-1:0] BL_FULL = 3'h7;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 10;
   localparam int ROW_PRECHARGE_NS = 20;
   localparam int RP_CYCLES_I      = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_W             = $clog2(RP_CYCLES_I + 1);
   localparam logic [RP_W-1:0] RP_CYCLES = RP_W'(RP_CYCLES_I);
   localparam logic [1:0] WR_AP_CLK = 2'h2;

   // ------------------------------------------------------------------
   // Reset values and bank states
   // ------------------------------------------------------------------
   localparam logic [DQ_W-1:0] DQ_RESET = 16'h0000;

   typedef enum logic [1:0] {
      BANK_IDLE   = 2'h0,
      BANK_ACTIVE = 2'h1,
      BANK_PRECH  = 2'h3
   } sdci_bank_e;

endpackage : sdci_pkg

// File: dv/sdci_checker.sv
// Port-level assertions for the DRAM command core.
// Assumes it is bound to sdci_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sdci_checker (
   input wire logic                        i_clk,
   input wire logic                        i_sys_rst,
   input wire logic                        i_cs_n,
   input wire logic                        i_ras_n,
   input wire logic                        i_cas_n,
   input wire logic                        i_we_n,
   input wire logic [sdci_pkg::ADDR_W-1:0] i_addr,
   input wire logic                        i_upper_byte_mask,
   input wire logic                        i_lower_byte_mask,
   input wire logic                        i_cas_latency3,
   input wire logic [sdci_pkg::LANES-1:0]  o_dq_oe,
   input wire logic [sdci_pkg::BANKS-1:0]  o_bank_active,
   input wire logic                        o_read_busy,
   input wire logic                        o_write_busy
);
   import sdci_pkg::*;
   logic [2:0] cmd;
   logic       act0;
   logic       pre0;
   logic       stop;
   assign cmd  = i_cs_n ? 3'h7 : {i_ras_n, i_cas_n, i_we_n};
   assign act0 = (cmd == CMD_ACT) && !i_addr[BANK_SELECT_BIT];
   assign pre0 = (cmd == CMD_PRE) && !i_addr[10] && !i_addr[BANK_SELECT_BIT];
   assign stop = (cmd == CMD_BST) || ((cmd == CMD_PRE) && i_addr[10]);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_tail2;
      ##1 (o_dq_oe != 2'h0) ##1 (o_dq_oe == 2'h0);
   endsequence
   sequence s_tail3;
      ##2 (o_dq_oe != 2'h0) ##1 (o_dq_oe == 2'h0);
   endsequence
   property p_rst;
      $fell(i_sys_rst) |-> (o_dq_oe == 2'h0) && (o_bank_active == 2'h0) && !o_read_busy
         && !o_write_busy;
   endproperty
   property p_pre_all;
      (cmd == CMD_PRE) && i_addr[ALL_BANK_PRECHARGE_BIT] |=> (o_bank_active == 2'h0);
   endproperty
   property p_pre_b0;
      pre0 |=> !o_bank_active[0] && $stable(o_bank_active[1]);
   endproperty
   property p_act;
      $rose(o_bank_active[0]) |-> $past(act0);
   endproperty
   property p_mask_up;
      i_upper_byte_mask |-> ##2 !o_dq_oe[1];
   endproperty
   property p_mask_lo;
      i_lower_byte_mask |-> ##2 !o_dq_oe[0];
   endproperty
   property p_lane;
      o_dq_oe[0] && !$past(i_upper_byte_mask, 2) |-> o_dq_oe[1];
   endproperty
   property p_tail2;
      stop && o_read_busy && !i_cas_latency3 |-> s_tail2;
   endproperty
   property p_tail3;
      stop && o_read_busy && i_cas_latency3 |-> s_tail3;
   endproperty
   property p_bst_wr;
      (cmd == CMD_BST) && o_write_busy |=> !o_write_busy;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   a_pre_all: assert property (p_pre_all) else $error("all-bank precharge missed");
   a_pre_b0: assert property (p_pre_b0) else $error("single-bank precharge wrong");
   a_act: assert property (p_act) else $error("bank opened without activate");
   a_mask_up: assert property (p_mask_up) else $error("upper lane not floated");
   a_mask_lo: assert property (p_mask_lo) else $error("lower lane not floated");
   a_lane: assert property (p_lane) else $error("upper lane did not resume");
   a_tail2: assert property (p_tail2) else $error("read tail wrong at latency two");
   a_tail3: assert property (p_tail3) else $error("read tail wrong at latency three");
   a_bst_wr: assert property (p_bst_wr) else $error("write kept going after stop");
endmodule : sdci_checker
bind sdci_core sdci_checker u_chk (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n),
   .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_addr(i_addr),
   .i_upper_byte_mask(i_upper_byte_mask), .i_lower_byte_mask(i_lower_byte_mask),
   .i_cas_latency3(i_cas_latency3), .o_dq_oe(o_dq_oe), .o_bank_active(o_bank_active),
   .o_read_busy(o_read_busy), .o_write_busy(o_write_busy));
`default_nettype wire

// File: dv/sdci_ctrl_model.sv
// Controller model driving command, address, write data and byte masks.
// Assumes callers start each cycle just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module sdci_ctrl_model (
   input  wire logic                        i_clk,
   output logic                             o_cs_n,
   output logic [2:0]                       o_cmd,
   output logic [sdci_pkg::ADDR_W-1:0]      o_addr,
   output logic [sdci_pkg::DQ_W-1:0]        o_dq,
   output logic [1:0]                       o_mask
);
   import sdci_pkg::*;
   initial begin
      o_cs_n = 1'b1;
      o_cmd  = 3'h7;
      o_addr = '0;
      o_dq   = '0;
      o_mask = 2'h0;
   end
   // one command per clock
   // Released data lines invert each clock, so a stale word returns on every second released clock.
   task automatic cyc(input logic [2:0] c, input logic [ADDR_W-1:0] a,
                      input logic drv, input logic [DQ_W-1:0] d, input logic [1:0] m);
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      o_cmd  <= c;
      o_addr <= a;
      o_dq   <= drv ? d : ~o_dq;
      o_mask <= m;
   endtask : cyc
endmodule : sdci_ctrl_model
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench: writes, interrupted bursts, masks and precharges.
// Assumes a shadow memory of row 0 predicts every read word.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sdci_pkg::*;
   localparam logic [2:0] NOP = 3'h7;
   logic              i_clk, i_sys_rst, cl3, cs_n;
   logic [2:0]        cmd, bl;
   logic [ADDR_W-1:0] addr;
   logic [DQ_W-1:0]   dq_in, o_dq;
   logic [1:0]        mask, o_dq_oe, o_bank_active;
   logic              o_read_busy, o_write_busy;
   logic [DQ_W-1:0]   sh [2][256];
   logic [17:0]       exp_q [$];
   int                fail_count = 0;
   int                cmp_count = 0;
   int                i;
   integer            seed = 32;
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   sdci_ctrl_model u_ctrl (.i_clk(i_clk), .o_cs_n(cs_n), .o_cmd(cmd), .o_addr(addr),
                           .o_dq(dq_in), .o_mask(mask));
   sdci_core #(.ROW_W(2)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(cs_n),
      .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_addr(addr),
      .i_upper_byte_mask(mask[1]), .i_lower_byte_mask(mask[0]), .i_dq(dq_in),
      .i_cas_latency3(cl3), .i_burst_len(bl), .i_interleave(1'b0), .o_dq(o_dq),
      .o_dq_oe(o_dq_oe), .o_bank_active(o_bank_active), .o_read_busy(o_read_busy),
      .o_write_busy(o_write_busy));
   function automatic int colk(input int base, input logic [2:0] c, input int k);
      int len;
      len = (c == BL_FULL) ? 256 : (1 << c);
      return (base & ~(len - 1)) | ((base + k) & (len - 1));
   endfunction : colk
   task automatic bad(input string s);
      fail_count++;
      $display("MISMATCH %0t %s", $time, s);
   endtask : bad
   task automatic chk_bank(input logic [1:0] e);
      cmp_count++;
      if (o_bank_active !== e || o_read_busy !== 1'b0 || o_write_busy !== 1'b0) bad("bank state");
   endtask : chk_bank
   task automatic chk_word(input logic [17:0] e);
      cmp_count++;
      if (o_dq_oe !== e[17:16] || (e[16] && o_dq[7:0] !== e[7:0])
          || (e[17] && o_dq[15:8] !== e[15:8])) bad("read word");
   endtask : chk_word
   task automatic idle(input int n);
      repeat (n) u_ctrl.cyc(NOP, '0, 1'b0, '0, 2'h0);
      #1;
   endtask : idle
   task automatic act(input int b);
      u_ctrl.cyc(CMD_ACT, ADDR_W'(b << 11), 1'b0, '0, 2'h0);
   endtask : act
   // write burst, optional other-bank precharge at cycle pc
   task automatic wr(input int b, c, input logic [2:0] lc, input int n, ap, mk, pc);
      logic [DQ_W-1:0] d;
      int k;
      bl <= lc;
      for (k = 0; k < n; k++) begin
         d = DQ_W'($random(seed));
         u_ctrl.cyc((k == 0) ? CMD_WR : ((k == pc) ? CMD_PRE : NOP),
                    ADDR_W'((k == pc) ? ((1 - b) << 11) : ((b << 11) | (ap << 10) | c)),
                    1'b1, d, {1'b0, k == mk});
         sh[b][colk(c, lc, k)][15:8] = d[15:8];
         if (k != mk) sh[b][colk(c, lc, k)][7:0] = d[7:0];
      end
   endtask : wr
   // read burst, upper lane masked for cycles mf to mt-1
   task automatic rd(input int b, c, input logic [2:0] lc, input int n, mf, mt);
      int k;
      int j;
      for (k = 0; k < n && k < ((lc == BL_FULL) ? 256 : (1 << lc)); k++) begin
         j = k + (cl3 ? 1 : 0);
         exp_q.push_back({!(j >= mf && j < mt), 1'b1, sh[b][colk(c, lc, k)]});
      end
      bl <= lc;
      for (k = 0; k < n; k++)
         u_ctrl.cyc((k == 0) ? CMD_RD : NOP, ADDR_W'((b << 11) | c), 1'b0, '0,
                    {k >= mf && k < mt, 1'b0});
   endtask : rd
   always @(negedge i_clk) begin
      if (!i_sys_rst && o_dq_oe !== 2'h0) begin
         if (exp_q.size() == 0) bad("unexpected read word");
         else chk_word(exp_q.pop_front());
      end
   end
   task automatic close_out();
      if (exp_q.size() != 0) bad("read words missing");
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (5000) @(posedge i_clk);
      bad("watchdog expired");
      close_out();
   end
   initial begin
      i_sys_rst = 1'b1;
      cl3 = 1'b0;
      bl = BL_1;
      repeat (5) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      idle(1);
      chk_bank(2'h0);
      for (i = 0; i < 2; i++) begin
         cl3 <= i[0];
         act(0);
         act(1);
         idle(1);
         chk_bank(2'h3);
         // Full-page fill wraps over columns 0 and 1, then stops.
         wr(0, 0, BL_FULL, 258, 1, 9, -1);
         u_ctrl.cyc(CMD_BST, 12'h000, 1'b1, DQ_W'($random(seed)), 2'h0);
         wr(1, 0, BL_FULL, 258, 1, 9, -1);
         u_ctrl.cyc(CMD_BST, 12'h800, 1'b1, DQ_W'($random(seed)), 2'h0);
         idle(1);
         chk_bank(2'h3);
         wr(0, 0, BL_4, 2, 0, 9, -1);
         wr(0, 2, BL_4, 4, 0, 1, -1);
         rd(0, 0, BL_8, 4, 9, 9);
         rd(0, 4, BL_4, 4, 1, 3);
         rd(1, 253, BL_FULL, 6, 9, 9);
         u_ctrl.cyc(CMD_BST, 12'h800, 1'b0, '0, 2'h0);
         idle(4);
         wr(1, 8, BL_8, 8, 0, 9, 3);
         idle(1);
         chk_bank(2'h2);
         rd(1, 8, BL_8, 8, 9, 9);
         idle(4);
         wr(1, 16, BL_8, 3, 0, 9, -1);
         u_ctrl.cyc(CMD_PRE, 12'h800, 1'b1, DQ_W'($random(seed)), 2'h3);
         idle(2);
         act(1);
         idle(1);
         chk_bank(2'h2);
         rd(1, 16, BL_8, 8, 9, 9);
         idle(4);
         act(0);
         wr(0, 32, BL_4, 4, 1, 9, -1);
         idle(2);
         chk_bank(2'h3);
         idle(1);
         chk_bank(2'h2);
         idle(1);
         act(0);
         idle(1);
         chk_bank(2'h3);
         rd(0, 32, BL_8, 3, 9, 9);
         u_ctrl.cyc(CMD_PRE, 12'h400, 1'b0, '0, 2'h0);
         idle(1);
         chk_bank(2'h0);
         idle(4);
      end
      close_out();
   end
endmodule : testbench
`default_nettype wire
